// *** logic/lcd_compositor_pkg.sv ***
package lcd_compositor_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses, one word each)
   localparam logic [11:0] REG_CTRL       = 12'h000; // mode and raster enable
   localparam logic [11:0] REG_BG         = 12'h004; // background color
   localparam logic [11:0] REG_DISP_SIZE  = 12'h008; // active width and height
   localparam logic [11:0] REG_HTIMING    = 12'h00c; // line sync pulse and porches
   localparam logic [11:0] REG_VTIMING    = 12'h010; // frame sync pulse and porches
   localparam logic [11:0] REG_ERR_STATUS = 12'h014; // layer parameter error flags
   localparam logic [11:0] REG_BAR_BASE   = 12'h040; // eight test bar colors
   localparam logic [11:0] REG_LAYER_BASE = 12'h200; // layer descriptors
   localparam logic [11:0] REG_LAYER_END  = 12'h400; // first address past them

   ////////////////////////////////////////////////////////////////////////////
   // control fields and mode codes
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_RUN_BIT  = 2;
   localparam logic [1:0]  MODE_OFF      = 2'h0;
   localparam logic [1:0]  MODE_NORMAL   = 2'h1;
   localparam logic [1:0]  MODE_BARS     = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // layers and descriptor words
   localparam int NUM_LAYERS = 16;
   localparam int DESC_WORDS = 7;
   localparam int NUM_BARS   = 8;
   localparam logic [2:0] DESC_SIZE  = 3'h0; // width, height
   localparam logic [2:0] DESC_POS   = 3'h1; // x, y on panel
   localparam logic [2:0] DESC_BASE  = 3'h2; // address of top-left pixel
   localparam logic [2:0] DESC_FMT   = 3'h3; // encoding, blend, tile, enable
   localparam logic [2:0] DESC_CKMAX = 3'h4; // chroma key upper bound
   localparam logic [2:0] DESC_CKMIN = 3'h5; // chroma key lower bound
   localparam logic [2:0] DESC_TILE  = 3'h6; // tile width-1, height-1

   // field positions
   localparam int DIM_W       = 12;
   localparam int LO_LSB      = 0;  // width / x / tile width-1
   localparam int HI_LSB      = 16; // height / y / tile height-1
   localparam int FMT_EN_BIT  = 31;
   localparam int FMT_TILE_BIT= 30;
   localparam int FMT_BL_LSB  = 28;
   localparam int FMT_ENC_LSB = 16;
   localparam logic [3:0] ENC_ARGB8888 = 4'h0; // only encoding fetched
   localparam logic [1:0] BLEND_OPAQUE = 2'h0;
   localparam logic [1:0] BLEND_ALPHA  = 2'h1;
   localparam logic [1:0] BLEND_CHROMA = 2'h2;

   // timing fields
   localparam int T_W      = 10;
   localparam int T_PW_LSB = 0;
   localparam int T_BP_LSB = 10;
   localparam int T_FP_LSB = 20;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [23:0] BG_RESET    = 24'h000000; // black
   localparam logic [11:0] DISP_W_RST  = 12'h140;
   localparam logic [11:0] DISP_H_RST  = 12'h0f0;
   localparam logic [29:0] HTIME_RST   = 30'h0280a00a;
   localparam logic [29:0] VTIME_RST   = 30'h00200802;
   localparam logic [23:0] BAR_RESET [NUM_BARS] = '{
      24'h000000, 24'h0000ff, 24'hff0000, 24'hff00ff,
      24'h00ff00, 24'h00ffff, 24'hffff00, 24'hffffff};

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic        hsync;   // line sync
      logic        vsync;   // frame sync
      logic        dataEn;  // data enable
      logic [23:0] rgb;     // pixel data
   } raster_t;

   typedef struct packed {
      logic        hs;
      logic        vs;
      logic        de;
      logic [11:0] x;
      logic [11:0] y;
   } scan_t;

endpackage

// *** logic/scan_gen.sv ***
`timescale 1ns/1ps
module scan_gen
   import lcd_compositor_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // pacing
   input  wire logic        tick,
   input  wire logic        run,
   // geometry
   input  wire logic [11:0] dispW,
   input  wire logic [11:0] dispH,
   input  wire logic [29:0] hTiming,
   input  wire logic [29:0] vTiming,
   // position
   output scan_t            scan
);

   logic [12:0] hCnt_r;      // pixel within line
   logic [12:0] vCnt_r;      // line within frame
   logic [12:0] hActStart;   // first active pixel
   logic [12:0] hTotal;      // pixels per line
   logic [12:0] vActStart;   // first active line
   logic [12:0] vTotal;      // lines per frame
   logic        hWrap;       // last pixel of line
   logic        hAct;
   logic        vAct;

   // horizontal in pixel clocks, vertical in lines
   assign hActStart = 13'(hTiming[T_PW_LSB+:T_W]) + 13'(hTiming[T_BP_LSB+:T_W]);
   assign hTotal    = hActStart + 13'(dispW) + 13'(hTiming[T_FP_LSB+:T_W]);
   assign vActStart = 13'(vTiming[T_PW_LSB+:T_W]) + 13'(vTiming[T_BP_LSB+:T_W]);
   assign vTotal    = vActStart + 13'(dispH) + 13'(vTiming[T_FP_LSB+:T_W]);
   assign hWrap     = (hCnt_r + 13'h1 >= hTotal);
   assign hAct      = (hCnt_r >= hActStart) && (hCnt_r < hActStart + 13'(dispW));
   assign vAct      = (vCnt_r >= vActStart) && (vCnt_r < vActStart + 13'(dispH));

   ////////////////////////////////////////////////////////////////////////////
   // counters advance one pixel per rising pixel-clock edge, idle at zero
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         hCnt_r <= 13'h0;
         vCnt_r <= 13'h0;
      end else if (tick) begin
         hCnt_r <= hWrap ? 13'h0 : hCnt_r + 13'h1;
         if (hWrap) begin
            vCnt_r <= (vCnt_r + 13'h1 >= vTotal) ? 13'h0 : vCnt_r + 13'h1;
         end
      end
   end

   // decoded position
   assign scan.hs = hCnt_r < 13'(hTiming[T_PW_LSB+:T_W]);
   assign scan.vs = vCnt_r < 13'(vTiming[T_PW_LSB+:T_W]);
   assign scan.de = hAct && vAct;
   assign scan.x  = 12'(hCnt_r - hActStart);
   assign scan.y  = 12'(vCnt_r - vActStart);

endmodule

// *** logic/display_compositor.sv ***
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module display_compositor
   import lcd_compositor_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [11:0] regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   // panel side
   input  wire logic        pclkIn,
   output raster_t          rasterOut,
   // memory fetch port
   output logic             fetchReq,
   output logic      [31:0] fetchAddr,
   input  wire logic        fetchAck,
   input  wire logic [31:0] fetchData
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   // flat index of a descriptor word
   function automatic logic [6:0] descIndex(input logic [3:0] layer, input logic [2:0] word);
      descIndex = 7'(layer * DESC_WORDS) + 7'(word);
   endfunction
   // lowest set bit wins, msb of result says any set
   function automatic logic [4:0] firstSet(input logic [NUM_LAYERS-1:0] v);
      firstSet = 5'h0;
      for (int i = NUM_LAYERS - 1; i >= 0; i--) begin
         if (v[i]) begin
            firstSet = {1'b1, 4'(i)};
         end
      end
   endfunction
   // weighted mix of one color channel
   function automatic logic [7:0] mixCh(input logic [7:0] a, input logic [7:0] f,
                                        input logic [7:0] b);
      logic [15:0] sum;
      sum   = 16'(a * f) + 16'((8'hff - a) * b);
      mixCh = sum[15:8];
   endfunction
   // which test bar a pixel falls in
   function automatic logic [2:0] barIndex(input logic [11:0] x, input logic [11:0] w);
      logic [14:0] lim;
      barIndex = 3'h0;
      lim      = 15'h0;
      for (int k = 1; k < NUM_BARS; k++) begin
         lim = 15'(k) * {3'h0, w};
         if ({x, 3'h0} >= lim) begin
            barIndex = 3'(k);
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [1:0]  mode_r;                          // operating_mode_select
   logic        rasterEn_r;                      // raster output enable
   logic [23:0] bgColor_r;                       // background_color
   logic [23:0] barColor_r [NUM_BARS];           // test_bar_color
   logic [11:0] dispW_r;                         // active pixels per line
   logic [11:0] dispH_r;                         // active lines per frame
   logic [29:0] hTiming_r;                       // line sync and porches
   logic [29:0] vTiming_r;                       // frame sync and porches
   logic [31:0] desc_r [NUM_LAYERS*DESC_WORDS];  // layer descriptors
   logic [31:0] regRdData_r;                     // read answer

   // address decode
   logic        hitLayer;
   logic        hitBar;
   logic [6:0]  descSel;
   logic [2:0]  barSel;
   logic [31:0] rdMux;
   logic [NUM_LAYERS-1:0] layerErr;              // layer_param_error_status
   assign hitLayer = (regAddr >= REG_LAYER_BASE) && (regAddr < REG_LAYER_END)
                     && (regAddr[4:2] < 3'(DESC_WORDS)) && (regAddr[1:0] == 2'h0);
   assign hitBar   = (regAddr[11:5] == REG_BAR_BASE[11:5]) && (regAddr[1:0] == 2'h0);
   assign descSel  = descIndex(regAddr[8:5], regAddr[4:2]);
   assign barSel   = regAddr[4:2];

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_r     <= MODE_OFF;
         rasterEn_r <= 1'b0;
         bgColor_r  <= BG_RESET;
         dispW_r    <= DISP_W_RST;
         dispH_r    <= DISP_H_RST;
         hTiming_r  <= HTIME_RST;
         vTiming_r  <= VTIME_RST;
         for (int i = 0; i < NUM_BARS; i++) begin
            barColor_r[i] <= BAR_RESET[i];
         end
         for (int i = 0; i < NUM_LAYERS * DESC_WORDS; i++) begin
            desc_r[i] <= 32'h0;
         end
      end else if (regWr) begin
         if (regAddr == REG_CTRL) begin
            // both fields land in the same edge so all pins start together
            mode_r     <= regWrData[CTRL_MODE_LSB+:2];
            rasterEn_r <= regWrData[CTRL_RUN_BIT];
         end
         if (regAddr == REG_BG) begin
            bgColor_r <= regWrData[23:0];
         end
         if (regAddr == REG_DISP_SIZE) begin
            dispW_r <= regWrData[LO_LSB+:DIM_W];
            dispH_r <= regWrData[HI_LSB+:DIM_W];
         end
         if (regAddr == REG_HTIMING) begin
            hTiming_r <= regWrData[29:0];
         end
         if (regAddr == REG_VTIMING) begin
            vTiming_r <= regWrData[29:0];
         end
         if (hitBar) begin
            barColor_r[barSel] <= regWrData[23:0];
         end
         if (hitLayer) begin
            desc_r[descSel] <= regWrData;
         end
      end
   end

   // read selection, unmapped reads as zero
   assign rdMux = (regAddr == REG_CTRL)       ? {29'h0, rasterEn_r, mode_r} :
                  (regAddr == REG_BG)         ? {8'h0, bgColor_r} :
                  (regAddr == REG_DISP_SIZE)  ? {4'h0, dispH_r, 4'h0, dispW_r} :
                  (regAddr == REG_HTIMING)    ? {2'h0, hTiming_r} :
                  (regAddr == REG_VTIMING)    ? {2'h0, vTiming_r} :
                  (regAddr == REG_ERR_STATUS) ? {16'h0, layerErr} :
                  hitBar                      ? {8'h0, barColor_r[barSel]} :
                  hitLayer                    ? desc_r[descSel] : 32'h0;
   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData_r <= 32'h0;
      end else begin
         regRdData_r <= regRd ? rdMux : 32'h0;
      end
   end
   assign regRdData = regRdData_r;

   ////////////////////////////////////////////////////////////////////////////
   // pixel clock sampling and edge detect
   logic pclkSync1_r;  // first stage, read only by the second
   logic pclkSync2_r;
   logic pclkSync3_r;
   logic tick;         // rising pixel clock edge
   logic tickD_r;      // cycle after the edge: new position valid
   logic run;          // raster outputs active
   logic normal;       // layer composition active
   always_ff @(posedge clk) begin
      if (rst) begin
         pclkSync1_r <= 1'b0;
         pclkSync2_r <= 1'b0;
         pclkSync3_r <= 1'b0;
         tickD_r     <= 1'b0;
      end else begin
         pclkSync1_r <= pclkIn;
         pclkSync2_r <= pclkSync1_r;
         pclkSync3_r <= pclkSync2_r;
         tickD_r     <= tick;
      end
   end
   assign tick   = pclkSync2_r && !pclkSync3_r;
   assign run    = rasterEn_r && (mode_r == MODE_NORMAL || mode_r == MODE_BARS);
   assign normal = run && (mode_r == MODE_NORMAL);

   ////////////////////////////////////////////////////////////////////////////
   // raster position
   scan_t scan;
   scan_gen u_scan (
      .clk     (clk),
      .rst     (rst),
      .tick    (tick),
      .run     (run),
      .dispW   (dispW_r),
      .dispH   (dispH_r),
      .hTiming (hTiming_r),
      .vTiming (vTiming_r),
      .scan    (scan)
   );

   ////////////////////////////////////////////////////////////////////////////
   // per-layer checks, coverage and fetch address
   logic [NUM_LAYERS-1:0] layerHit;
   logic [31:0]           layerAddr [NUM_LAYERS];
   for (genvar g = 0; g < NUM_LAYERS; g++) begin : g_layer
      logic [31:0] dSize, dPos, dBase, dFmt, dTile;
      logic [11:0] w, h, px, py, relX, relY, tx, ty;
      logic [12:0] stride;
      logic [24:0] pixOfs;
      logic        en, tile;
      assign dSize = desc_r[g*DESC_WORDS + int'(DESC_SIZE)];
      assign dPos  = desc_r[g*DESC_WORDS + int'(DESC_POS)];
      assign dBase = desc_r[g*DESC_WORDS + int'(DESC_BASE)];
      assign dFmt  = desc_r[g*DESC_WORDS + int'(DESC_FMT)];
      assign dTile = desc_r[g*DESC_WORDS + int'(DESC_TILE)];
      assign w     = dSize[LO_LSB+:DIM_W];
      assign h     = dSize[HI_LSB+:DIM_W];
      assign px    = dPos[LO_LSB+:DIM_W];
      assign py    = dPos[HI_LSB+:DIM_W];
      assign en    = dFmt[FMT_EN_BIT];
      assign tile  = dFmt[FMT_TILE_BIT];
      // enabled layer with empty size, unknown encoding, off-panel or unaligned
      assign layerErr[g] = en && (w == 12'h0 || h == 12'h0
                           || dFmt[FMT_ENC_LSB+:4] != ENC_ARGB8888
                           || 13'(px) + 13'(w) > 13'(dispW_r)
                           || 13'(py) + 13'(h) > 13'(dispH_r)
                           || dBase[1:0] != 2'h0);
      // a layer in error takes no part in the picture
      assign layerHit[g] = en && !layerErr[g]
                           && scan.x >= px && 13'(scan.x) < 13'(px) + 13'(w)
                           && scan.y >= py && 13'(scan.y) < 13'(py) + 13'(h);
      // tiled layers repeat one tile; tile sizes are powers of two
      assign relX   = scan.x - px;
      assign relY   = scan.y - py;
      assign tx     = tile ? (relX & dTile[LO_LSB+:DIM_W]) : relX;
      assign ty     = tile ? (relY & dTile[HI_LSB+:DIM_W]) : relY;
      assign stride = tile ? 13'(dTile[LO_LSB+:DIM_W]) + 13'h1 : 13'(w);
      assign pixOfs = 25'(ty * stride) + 25'(tx);
      assign layerAddr[g] = dBase + 32'({pixOfs, 2'h0});
   end

   ////////////////////////////////////////////////////////////////////////////
   // winner selection and its blend parameters
   logic [4:0]  win;        // {valid, index}
   logic [31:0] winFmt;
   logic [23:0] ckMax;
   logic [23:0] ckMin;
   assign win    = firstSet(layerHit);
   assign winFmt = desc_r[descIndex(win[3:0], DESC_FMT)];
   assign ckMax  = desc_r[descIndex(win[3:0], DESC_CKMAX)][23:0];
   assign ckMin  = desc_r[descIndex(win[3:0], DESC_CKMIN)][23:0];

   ////////////////////////////////////////////////////////////////////////////
   // memory fetch, one pixel per pixel period
   typedef enum logic {FETCH_IDLE, FETCH_BUSY} fetch_state_t;
   fetch_state_t fetchState_r;
   logic [31:0]  fetchAddr_r;
   logic [31:0]  pixData_r;     // fetched pixel
   logic         pixValid_r;    // pixData_r belongs to current position
   logic         fetchCur_r;    // outstanding fetch is for current position
   logic         launch;
   // only in normal mode with raster running, only for a covered pixel
   assign launch = tickD_r && normal && scan.de && win[4]
                   && (fetchState_r == FETCH_IDLE);
   always_ff @(posedge clk) begin
      if (rst) begin
         fetchState_r <= FETCH_IDLE;
         fetchAddr_r  <= 32'h0;
         pixData_r    <= 32'h0;
      end else begin
         unique case (fetchState_r)
            FETCH_IDLE: begin
               if (launch) begin
                  fetchState_r <= FETCH_BUSY;
                  fetchAddr_r  <= layerAddr[win[3:0]];
               end
            end
            FETCH_BUSY: begin
               // request holds until taken, even past a pixel edge
               if (fetchAck) begin
                  fetchState_r <= FETCH_IDLE;
                  pixData_r    <= fetchData;
               end
            end
         endcase
      end
   end

   // a late answer is dropped at the next pixel edge
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         fetchCur_r <= 1'b0;
         pixValid_r <= 1'b0;
      end else begin
         if (launch) begin
            fetchCur_r <= 1'b1;
         end
         if (fetchState_r == FETCH_BUSY && fetchAck && fetchCur_r) begin
            pixValid_r <= 1'b1;
         end
      end
   end

   assign fetchReq  = (fetchState_r == FETCH_BUSY);
   assign fetchAddr = fetchAddr_r;

   ////////////////////////////////////////////////////////////////////////////
   // pixel composition
   logic [23:0] fg;
   logic [7:0]  fgAlpha;
   logic        keyed;
   logic [23:0] layerPix;
   logic [23:0] normalPix;
   logic [23:0] pixel;
   assign fg      = pixData_r[23:0];
   assign fgAlpha = pixData_r[31:24];
   assign keyed   = fg[23:16] >= ckMin[23:16] && fg[23:16] <= ckMax[23:16]
                    && fg[15:8] >= ckMin[15:8] && fg[15:8] <= ckMax[15:8]
                    && fg[7:0] >= ckMin[7:0] && fg[7:0] <= ckMax[7:0];
   // blend over the background according to the winner's mode
   assign layerPix =
      (winFmt[FMT_BL_LSB+:2] == BLEND_ALPHA) ?
         {mixCh(fgAlpha, fg[23:16], bgColor_r[23:16]),
          mixCh(fgAlpha, fg[15:8], bgColor_r[15:8]),
          mixCh(fgAlpha, fg[7:0], bgColor_r[7:0])} :
      (winFmt[FMT_BL_LSB+:2] == BLEND_CHROMA && keyed) ? bgColor_r :
      fg;
   // only the winning layer over the background; nothing shown leaves background
   assign normalPix = (win[4] && pixValid_r) ? layerPix : bgColor_r;
   assign pixel     = (mode_r == MODE_BARS) ?
                      barColor_r[barIndex(scan.x, dispW_r)] : normalPix;

   ////////////////////////////////////////////////////////////////////////////
   // panel outputs, updated on each rising pixel clock edge
   raster_t rasterOut_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         rasterOut_r <= '0;
      end else if (!run) begin
         rasterOut_r <= '0;
      end else if (tick) begin
         rasterOut_r.hsync  <= scan.hs;
         rasterOut_r.vsync  <= scan.vs;
         rasterOut_r.dataEn <= scan.de;
         rasterOut_r.rgb    <= scan.de ? pixel : 24'h0;
      end
   end

   assign rasterOut = rasterOut_r;
endmodule

// *** bench/display_compositor_properties.sv ***
`timescale 1ns/1ps
module display_compositor_properties
   import lcd_compositor_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register port
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdData,
   // panel and memory
   input wire logic        pclkIn,
   input wire raster_t     rasterOut,
   input wire logic        fetchReq,
   input wire logic [31:0] fetchAddr,
   input wire logic        fetchAck,
   input wire logic [31:0] fetchData
);
   logic [2:0] ctrl_r; // shadow of mode and raster enable
   // follow every control write
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= 3'h0;
      end else if (regWr && regAddr == REG_CTRL) begin
         ctrl_r <= regWrData[2:0];
      end
   end
   wire logic showOn  = ctrl_r[2] && ctrl_r[0]; // modes 1 and 3 with raster on
   wire logic fetchOn = ctrl_r == 3'h5;         // only normal mode fetches
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_raster_idle: assert property (!showOn |=> rasterOut == '0)
      else $error("raster not idle while off");
   chk_fetch_quiet: assert property (!fetchOn [*8] |-> ##2 !fetchReq)
      else $error("fetch outside normal display");
   chk_read_pulse: assert property (!$past(regRd) |-> regRdData == 32'h0)
      else $error("read data outside its cycle");
   chk_ctrl_readback: assert property (regRd && regAddr == REG_CTRL
      |=> regRdData == {29'h0, ctrl_r}) else $error("control readback wrong");
   chk_fetch_held: assert property (fetchReq && !fetchAck
      |=> fetchReq && $stable(fetchAddr)) else $error("fetch request dropped");
   chk_fetch_drop: assert property (fetchAck |=> !fetchReq)
      else $error("fetch request after answer");
   chk_fetch_aligned: assert property (fetchReq |-> fetchAddr[1:0] == 2'h0)
      else $error("fetch from misaligned layer");
   chk_blank_black: assert property (!rasterOut.dataEn |-> rasterOut.rgb == 24'h0)
      else $error("pixel data outside active area");
   cov_fetch: cover property (fetchAck);
   cov_active: cover property (rasterOut.dataEn);
   cov_frame: cover property ($rose(rasterOut.vsync));
endmodule
bind display_compositor display_compositor_properties chk_i (.*);

// *** bench/panel_memory_model.sv ***
`timescale 1ns/1ps
module panel_memory_model
(
   // clock
   input  wire logic        clk,
   // free running pixel clock
   output logic             pclkIn,
   // memory answer
   input  wire logic [2:0]  lag,
   input  wire logic        fetchReq,
   input  wire logic [31:0] fetchAddr,
   output logic             fetchAck,
   output logic [31:0]      fetchData
);
   logic [2:0] waitR = 3'h0; // cycles spent on this request
   // pixel clock, phase kept off the system clock edges
   initial begin
      pclkIn = 1'b0;
      #1.3;
      forever #24 pclkIn = ~pclkIn;
   end
   // answer after lag cycles; data shows junk when not valid
   always @(posedge clk) begin
      fetchAck <= 1'b0;
      fetchData <= ~fetchAddr;
      if (fetchReq && !fetchAck && waitR == lag) begin
         fetchAck <= 1'b1;
         fetchData <= {8'hff, fetchAddr[23:0]};
         waitR <= 3'h0;
      end else if (fetchReq && !fetchAck) begin
         waitR <= waitR + 3'h1;
      end
   end
endmodule

// *** bench/tb_display_compositor.sv ***
`timescale 1ns/1ps
module tb_display_compositor import lcd_compositor_pkg::*;;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] regAddr = 12'h0;
   logic [31:0] regWrData = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdData;
   logic        pclkIn;
   raster_t     rasterOut;
   logic        fetchReq;
   logic [31:0] fetchAddr;
   logic        fetchAck;
   logic [31:0] fetchData;
   logic [2:0]  lag = 3'h0;
   int          miscompares = 0;
   int          compares = 0;
   int          cyc = 0;
   always #2 clk = ~clk;
   display_compositor uut (.*);
   panel_memory_model mem (.*);
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (miscompares == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         $display("MISMATCH timeout expected 0 seen 1");
         test_done;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      chk("regRdData", e, regRdData);
   endtask
   // layer at panel origin: size, base address, format word
   task automatic lay(input int i, input logic [31:0] sz, ba, fm);
      logic [11:0] b;
      b = REG_LAYER_BASE + 12'(i * 32);
      wr(b, sz);
      wr(b + 12'h4, 32'h0);
      wr(b + 12'h8, ba);
      wr(b + 12'hc, fm);
   endtask
   // first active pixel of the next frame
   task automatic pix(input logic [23:0] e);
      int n;
      n = 0;
      while (rasterOut.vsync !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      while (rasterOut.dataEn !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      // syncs low, data enable high, pixel color at first active pixel
      chk("rasterOut", {8'h01, e}, 32'(rasterOut));
      if (n >= 4000) begin
         miscompares++;
         $display("MISMATCH frameWait expected 1 seen 0");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(REG_BG, 32'h0);
      for (int k = 0; k < NUM_BARS; k++) begin
         rd(REG_BAR_BASE + 12'(4 * k), {8'h0, BAR_RESET[k]});
      end
      wr(REG_LAYER_BASE + 12'h1c, 32'h1);
      rd(REG_LAYER_BASE + 12'h1c, 32'h0);
      wr(12'h2b0, 32'habcdef);
      rd(12'h2b0, 32'habcdef);
      wr(12'h2b8, 32'h00030003);
      rd(12'h2b8, 32'h00030003);
      wr(REG_DISP_SIZE, 32'h00040008);
      wr(REG_HTIMING, 32'h00100401);
      wr(REG_VTIMING, 32'h00100401);
      wr(REG_BG, 32'h123456);
      wr(REG_CTRL, 32'h5);
      rd(REG_CTRL, 32'h5);
      pix(24'h123456);
      lay(3, 32'h00020004, 32'h100, 32'h80000000);
      pix(24'h000100);
      lay(1, 32'h00020004, 32'h200, 32'h80000000);
      pix(24'h000200);
      lag <= 3'h5;
      lay(0, 32'h00020004, 32'h301, 32'h80000000);
      lay(2, 32'h00020004, 32'h400, 32'h80010000);
      lay(4, 32'h00020000, 32'h500, 32'h80000000);
      wr(REG_ERR_STATUS, 32'h0);
      rd(REG_ERR_STATUS, 32'h15);
      pix(24'h000200);
      wr(12'h230, 32'h000300);
      wr(12'h234, 32'h000100);
      wr(12'h22c, 32'ha0000000);
      pix(24'h123456);
      lag <= 3'h0;
      wr(REG_BAR_BASE, 32'h008000);
      wr(REG_CTRL, 32'h7);
      pix(24'h008000);
      wr(REG_CTRL, 32'h6);
      repeat (2) @(negedge clk);
      chk("rasterOut", 32'h0, 32'(rasterOut));
      wr(REG_CTRL, 32'h7);
      repeat (20) @(posedge clk);
      wr(REG_CTRL, 32'h1);
      repeat (2) @(negedge clk);
      chk("rasterOut", 32'h0, 32'(rasterOut));
      test_done;
   end
endmodule
